// [hdl/stpo_cfg.svh]
`ifndef STPO_CFG_SVH
`define STPO_CFG_SVH
// Timing
`define STPO_CLK_NS 10
`define STPO_SAMPLE_NS 1000000
`define STPO_PULSE_NS 2000
// Widths
`define STPO_ADDR_W 4
`define STPO_DATA_W 32
`define STPO_FRAC_W 8
`define STPO_SMK_W 3
`define STPO_PW_W 16
// Register word offsets
`define STPO_REG_KIND 4'h0
`define STPO_REG_SMK 4'h1
`define STPO_REG_REF 4'h2
`define STPO_REG_STEP 4'h3
`define STPO_REG_TARGET 4'h4
`define STPO_REG_STATUS 4'h5
`define STPO_REG_ENC 4'h6
`define STPO_REG_AUX 4'h7
// Reset values and smoothing constant minimum
`define STPO_SMK_RST 3'h2
`define STPO_SMK_MIN 3'h1
`define STPO_POS_RST 32'h0000_0000
// Status bit positions
`define STPO_ST_DONE 0
`define STPO_ST_AP 1
`define STPO_ST_STEPPER 2
`define STPO_ST_BUSY 3
`endif

// [hdl/stpo_pkg.sv]
package stpo_pkg;
    // Motor kind codes: 2, -2, 2.5 and -2.5 map onto step codes
    typedef enum logic [2:0] {
        STPO_KIND_SERVO = 3'b000,
        STPO_KIND_STEP_LO = 3'b001,
        STPO_KIND_STEP_HI = 3'b010,
        STPO_KIND_STEP_LO_HALF = 3'b011,
        STPO_KIND_STEP_HI_HALF = 3'b100
    } stpo_kind_e;
    // Step pulse generator states
    typedef enum logic [0:0] {
        STPO_PS_IDLE = 1'b0,
        STPO_PS_PULSE = 1'b1
    } stpo_pstate_e;
endpackage : stpo_pkg

// [hdl/stpo_filt_if.sv]
`timescale 1ns/1ps
`include "stpo_cfg.svh"
interface stpo_filt_if;
    logic tick;
    logic [`STPO_SMK_W-1:0] smooth_k;
    logic signed [`STPO_DATA_W-1:0] ref_pos;
    logic load;
    logic signed [`STPO_DATA_W-1:0] load_val;
    logic signed [`STPO_DATA_W-1:0] filt_pos;
    modport axis (output tick, smooth_k, ref_pos, load, load_val, input filt_pos);
    modport filt (input tick, smooth_k, ref_pos, load, load_val, output filt_pos);
endinterface : stpo_filt_if

// [hdl/stpo_smooth.sv]
`timescale 1ns/1ps
`include "stpo_cfg.svh"
module stpo_smooth
    import stpo_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    stpo_filt_if.filt fb
);
    localparam int ACC_W = `STPO_DATA_W + `STPO_FRAC_W;
    logic signed [ACC_W-1:0] acc_q;
    logic signed [ACC_W:0] err;
    logic signed [ACC_W:0] acc_next;
    logic signed [ACC_W-1:0] rounded;
    logic [`STPO_SMK_W-1:0] shift;
    logic signed [`STPO_DATA_W-1:0] filt_q;

    // Zero smoothing is never allowed in stepper mode
    assign shift = (fb.smooth_k < `STPO_SMK_MIN) ? `STPO_SMK_MIN : fb.smooth_k;
    // Single pole: move a 2^-k fraction of the error each sample
    assign err = {fb.ref_pos[`STPO_DATA_W-1], fb.ref_pos, {`STPO_FRAC_W{1'b0}}} - {acc_q[ACC_W-1], acc_q};
    assign acc_next = {acc_q[ACC_W-1], acc_q} + (err >>> shift);
    assign rounded = acc_q + ACC_W'({1'b1, {(`STPO_FRAC_W-1){1'b0}}});
    assign fb.filt_pos = filt_q;

    // Filter state, reloaded by a position define
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= '0;
        end else if (ce_i) begin
            if (fb.load) begin
                acc_q <= {fb.load_val, {`STPO_FRAC_W{1'b0}}};
            end else if (fb.tick) begin
                acc_q <= acc_next[ACC_W-1:0];
            end
        end
    end

    // Rounded integer position seen by the step generator
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            filt_q <= `STPO_POS_RST;
        end else if (ce_i) begin
            filt_q <= fb.load ? fb.load_val : rounded[ACC_W-1:`STPO_FRAC_W];
        end
    end
endmodule : stpo_smooth

// [hdl/stpo_axis.sv]
`timescale 1ns/1ps
`include "stpo_cfg.svh"
module stpo_axis
    import stpo_pkg::*;
#(
    parameter int SAMPLE_CYC = `STPO_SAMPLE_NS / `STPO_CLK_NS
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [`STPO_ADDR_W-1:0] addr_i,
    input wire logic [`STPO_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`STPO_DATA_W-1:0] rdata_o,
    input wire logic prof_step_i,
    input wire logic prof_dir_i,
    input wire logic prof_done_i,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic aux_a_i,
    input wire logic aux_b_i,
    output logic step_o,
    output logic dir_o,
    output logic motion_complete_o,
    output logic after_profile_o,
    output logic loop_enable_o,
    output logic aux_enable_o
);
    localparam int PULSE_CYC = (`STPO_PULSE_NS + `STPO_CLK_NS - 1) / `STPO_CLK_NS;
    localparam logic [`STPO_PW_W-1:0] PW_NORM = `STPO_PW_W'(PULSE_CYC - 1);
    localparam logic [`STPO_PW_W-1:0] PW_HALF = `STPO_PW_W'(2 * PULSE_CYC - 1);
    localparam logic [`STPO_DATA_W-1:0] ONE = `STPO_DATA_W'(1);

    stpo_filt_if fb ();

    stpo_kind_e kind_q;
    logic [`STPO_SMK_W-1:0] smooth_k_q;
    logic signed [`STPO_DATA_W-1:0] ref_q;
    logic signed [`STPO_DATA_W-1:0] step_cnt_q;
    logic signed [`STPO_DATA_W-1:0] target_q;
    logic signed [`STPO_DATA_W-1:0] enc_q;
    logic signed [`STPO_DATA_W-1:0] aux_q;
    logic [`STPO_DATA_W-1:0] tick_cnt_q;
    logic tick_q;
    stpo_pstate_e pst_q;
    logic [`STPO_PW_W-1:0] pw_cnt_q;
    logic [3:0] pin_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] prev_q;
    logic stepper;
    logic active_low;
    logic half_kind;
    logic def_wr;
    logic start;
    logic start_dir;
    logic [1:0] enc_mv;
    logic [1:0] aux_mv;

    // Kind decode
    assign stepper = (kind_q != STPO_KIND_SERVO);
    assign active_low = (kind_q == STPO_KIND_STEP_LO) || (kind_q == STPO_KIND_STEP_LO_HALF);
    assign half_kind = (kind_q == STPO_KIND_STEP_LO_HALF) || (kind_q == STPO_KIND_STEP_HI_HALF);
    assign def_wr = wr_i && (addr_i == `STPO_REG_REF);

    // Filter connection
    assign fb.tick = tick_q;
    assign fb.smooth_k = smooth_k_q;
    assign fb.ref_pos = ref_q;
    assign fb.load = ce_i && def_wr;
    assign fb.load_val = wdata_i;

    stpo_smooth u_smooth (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .fb(fb)
    );

    // Quadrature step decode: 01 forward, 11 backward, 00 none
    function automatic logic [1:0] quad_move(input logic [1:0] p, input logic [1:0] c);
        case ({p, c})
            4'h1, 4'h7, 4'hE, 4'h8: quad_move = 2'h1;
            4'h2, 4'hB, 4'hD, 4'h4: quad_move = 2'h3;
            default: quad_move = 2'h0;
        endcase
    endfunction : quad_move

    // Two flip-flop synchronisers for the encoder pins
    assign pin_raw = {aux_b_i, aux_a_i, enc_b_i, enc_a_i};
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
                prev_q[i] <= 1'b0;
            end else if (ce_i) begin
                sync1_q[i] <= pin_raw[i];
                sync2_q[i] <= sync1_q[i];
                prev_q[i] <= sync2_q[i];
            end
        end
    end
    assign enc_mv = quad_move(prev_q[1:0], sync2_q[1:0]);
    assign aux_mv = quad_move(prev_q[3:2], sync2_q[3:2]);

    // Sample period tick
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            tick_q <= (tick_cnt_q == `STPO_DATA_W'(SAMPLE_CYC - 1));
            tick_cnt_q <= (tick_cnt_q == `STPO_DATA_W'(SAMPLE_CYC - 1)) ? '0 : tick_cnt_q + ONE;
        end
    end

    // Motor kind and smoothing constant
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            kind_q <= STPO_KIND_SERVO;
            smooth_k_q <= `STPO_SMK_RST;
        end else if (ce_i && wr_i) begin
            if (addr_i == `STPO_REG_KIND) begin
                case (wdata_i[2:0])
                    3'h0, 3'h1, 3'h2, 3'h3, 3'h4: kind_q <= stpo_kind_e'(wdata_i[2:0]);
                    default: kind_q <= kind_q;
                endcase
            end
            if (addr_i == `STPO_REG_SMK) begin
                smooth_k_q <= wdata_i[`STPO_SMK_W-1:0];
            end
        end
    end

    // Reference position from the profiler, before smoothing
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_q <= `STPO_POS_RST;
        end else if (ce_i) begin
            if (def_wr) begin
                ref_q <= wdata_i;
            end else if (prof_step_i) begin
                ref_q <= prof_dir_i ? ref_q + ONE : ref_q - ONE;
            end
        end
    end

    // One step per sample toward the filtered position
    assign start = stepper && tick_q && (pst_q == STPO_PS_IDLE) && (fb.filt_pos != step_cnt_q) && !def_wr;
    assign start_dir = (fb.filt_pos > step_cnt_q);

    // Step count of pulses actually sent
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt_q <= `STPO_POS_RST;
        end else if (ce_i) begin
            if (def_wr) begin
                step_cnt_q <= wdata_i;
            end else if (start) begin
                step_cnt_q <= start_dir ? step_cnt_q + ONE : step_cnt_q - ONE;
            end
        end
    end

    // Step pulse width state machine
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pst_q <= STPO_PS_IDLE;
            pw_cnt_q <= '0;
        end else if (ce_i) begin
            case (pst_q)
                STPO_PS_IDLE: begin
                    if (start) begin
                        pst_q <= STPO_PS_PULSE;
                        pw_cnt_q <= half_kind ? PW_HALF : PW_NORM;
                    end
                end
                STPO_PS_PULSE: begin
                    if (pw_cnt_q == '0) begin
                        pst_q <= STPO_PS_IDLE;
                    end else begin
                        pw_cnt_q <= pw_cnt_q - `STPO_PW_W'(1);
                    end
                end
                default: pst_q <= STPO_PS_IDLE;
            endcase
        end
    end

    // Driver pins with selected polarity; direction set one cycle before the step pin goes active
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_o <= 1'b0;
            dir_o <= 1'b0;
        end else if (ce_i) begin
            step_o <= (pst_q == STPO_PS_PULSE) ^ active_low;
            if (start) begin
                dir_o <= start_dir;
            end
        end
    end

    // Commanded target and completion flags
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_q <= `STPO_POS_RST;
            motion_complete_o <= 1'b0;
            after_profile_o <= 1'b0;
        end else if (ce_i) begin
            if (wr_i && addr_i == `STPO_REG_TARGET) begin
                target_q <= wdata_i;
            end
            motion_complete_o <= (step_cnt_q == target_q) && (pst_q == STPO_PS_IDLE);
            after_profile_o <= prof_done_i;
        end
    end

    // Main encoder count; loop enable and aux interface follow the kind
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_q <= `STPO_POS_RST;
            aux_q <= `STPO_POS_RST;
            loop_enable_o <= 1'b0;
            aux_enable_o <= 1'b0;
        end else if (ce_i) begin
            if (wr_i && addr_i == `STPO_REG_ENC) begin
                enc_q <= wdata_i;
            end else if (enc_mv[0]) begin
                enc_q <= enc_mv[1] ? enc_q - ONE : enc_q + ONE;
            end
            if (!stepper && aux_mv[0]) begin
                aux_q <= aux_mv[1] ? aux_q - ONE : aux_q + ONE;
            end
            loop_enable_o <= !stepper;
            aux_enable_o <= !stepper;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (rd_i) begin
                case (addr_i)
                    `STPO_REG_KIND: rdata_o <= {29'h0, kind_q};
                    `STPO_REG_SMK: rdata_o <= {29'h0, smooth_k_q};
                    `STPO_REG_REF: rdata_o <= ref_q;
                    `STPO_REG_STEP: rdata_o <= step_cnt_q;
                    `STPO_REG_TARGET: rdata_o <= target_q;
                    `STPO_REG_STATUS: begin
                        rdata_o[`STPO_ST_DONE] <= motion_complete_o;
                        rdata_o[`STPO_ST_AP] <= after_profile_o;
                        rdata_o[`STPO_ST_STEPPER] <= stepper;
                        rdata_o[`STPO_ST_BUSY] <= (pst_q == STPO_PS_PULSE);
                    end
                    `STPO_REG_ENC: rdata_o <= enc_q;
                    `STPO_REG_AUX: rdata_o <= aux_q;
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_step_start;
        ce_i && start && !start_dir;
    endsequence
    sequence s_define;
        ce_i && def_wr;
    endsequence

    a_low_idle_level: assert property (ce_i && kind_q == STPO_KIND_STEP_LO && pst_q == STPO_PS_IDLE |=> step_o)
        else $error("idle step pin not high in active low mode");
    a_high_pulse_level: assert property (ce_i && kind_q == STPO_KIND_STEP_HI && pst_q == STPO_PS_PULSE |=> step_o)
        else $error("step pin not high during active high pulse");
    a_half_width_len: assert property (ce_i && start && half_kind |=> pw_cnt_q == PW_HALF)
        else $error("half kind pulse width wrong");
    a_smk_reset_val: assert property ($fell(rst_i) |-> smooth_k_q == `STPO_SMK_RST)
        else $error("smoothing constant reset value wrong");
    a_ref_tracks: assert property (ce_i && prof_step_i && prof_dir_i && !def_wr |=> ref_q == $past(ref_q) + ONE)
        else $error("reference counter missed a profiler pulse");
    a_define_both: assert property (s_define |=> ref_q == $past(wdata_i) && step_cnt_q == $past(wdata_i))
        else $error("define did not load both counters");
    a_done_set: assert property (ce_i && step_cnt_q == target_q && pst_q == STPO_PS_IDLE |=> motion_complete_o)
        else $error("motion complete not raised");
    a_start_on_tick: assert property (start |-> tick_q && fb.filt_pos != step_cnt_q)
        else $error("step started outside a sample tick");
    a_count_down: assert property (s_step_start ##1 !def_wr |-> step_cnt_q == $past(step_cnt_q, 1) - ONE)
        else $error("step count did not follow a reverse step");
    a_aux_frozen: assert property (ce_i && stepper |=> $stable(aux_q))
        else $error("aux count moved in stepper mode");
    a_loop_off: assert property (ce_i && stepper |=> !loop_enable_o && !aux_enable_o)
        else $error("loop or aux enabled in stepper mode");
endmodule : stpo_axis

// [tb/stpo_drv_model.sv]
`timescale 1ns/1ps
// Behavioural stepper driver: counts one position step per active step edge
module stpo_drv_model (
    input wire logic sys_clk_i,
    input wire logic clr_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic active_low_i,
    output int pos_o
);
    logic lvl_q;
    wire logic act = step_i ^ active_low_i;
    initial pos_o = 0;
    initial lvl_q = 1'b0;
    // Step counting on the leading edge of the active level
    always @(posedge sys_clk_i) begin
        lvl_q <= act;
        if (clr_i) begin
            pos_o <= 0;
        end else if (act && !lvl_q) begin
            pos_o <= dir_i ? pos_o + 1 : pos_o - 1;
        end
    end
endmodule : stpo_drv_model

// [tb/stepper_pulse_output_axis_tb.sv]
`timescale 1ns/1ps
`include "stpo_cfg.svh"
module stepper_pulse_output_axis_tb;
    import stpo_pkg::*;
    logic sys_clk_i, rst_i, ce_i, wr_i, rd_i, prof_step_i, prof_dir_i, prof_done_i;
    logic enc_a_i, enc_b_i, aux_a_i, aux_b_i, step_o, dir_o, motion_complete_o;
    logic after_profile_o, loop_enable_o, aux_enable_o, act_lo, clr;
    logic [3:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rv;
    int err_count, check_count, mpos, l0, l5;

    stpo_axis #(.SAMPLE_CYC(500)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .prof_step_i(prof_step_i), .prof_dir_i(prof_dir_i), .prof_done_i(prof_done_i),
        .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .aux_a_i(aux_a_i), .aux_b_i(aux_b_i),
        .step_o(step_o), .dir_o(dir_o), .motion_complete_o(motion_complete_o),
        .after_profile_o(after_profile_o), .loop_enable_o(loop_enable_o), .aux_enable_o(aux_enable_o));

    stpo_drv_model drv (.sys_clk_i(sys_clk_i), .clr_i(clr), .step_i(step_o), .dir_i(dir_o),
        .active_low_i(act_lo), .pos_o(mpos));

    // Clock generation
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data is looked at in the single cycle after the read edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    task automatic rchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        rd(a, rv);
        chk(name, exp, rv);
    endtask : rchk

    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : clk

    task automatic prof(input int n, input logic up);
        prof_done_i <= 1'b0;
        repeat (n) begin
            @(posedge sys_clk_i);
            prof_step_i <= 1'b1;
            prof_dir_i <= up;
        end
        @(posedge sys_clk_i);
        prof_step_i <= 1'b0;
    endtask : prof

    task automatic model_clear;
        @(posedge sys_clk_i);
        clr <= 1'b1;
        @(posedge sys_clk_i);
        clr <= 1'b0;
    endtask : model_clear

    // Bounded wait for motion complete, judged once it returns
    task automatic wait_mc;
        int n;
        n = 0;
        while (motion_complete_o !== 1'b1 && n < 30000) begin
            @(posedge sys_clk_i);
            n++;
        end
        #1;
        chk("motion_complete_o", 1, motion_complete_o);
    endtask : wait_mc

    task automatic t_reset;
        rchk("kind", 0, 0);
        rchk("smooth k", 1, 2);
        rchk("ref", 2, 0);
        rchk("step", 3, 0);
        rchk("unmapped", 8, 0);
        chk("loop_enable_o", 1, loop_enable_o);
    endtask : t_reset

    // Each stepper kind: idle step level, loop and aux disabled
    task automatic t_kinds;
        for (int k = 1; k <= 4; k++) begin
            wr(0, k);
            clk(3);
            chk("step idle", (k == 1 || k == 3), step_o);
            chk("loop_enable_o", 0, loop_enable_o);
            chk("aux_enable_o", 0, aux_enable_o);
        end
        wr(0, 5);
        rchk("kind bad code", 0, 4);
    endtask : t_kinds

    task automatic t_move;
        wr(0, 1);
        act_lo <= 1'b1;
        model_clear();
        wr(4, 10);
        prof(10, 1'b1);
        rchk("ref", 2, 10);
        rd(3, rv);
        chk("step lag", 1, rv < 10);
        prof_done_i <= 1'b1;
        clk(2);
        chk("after_profile_o", 1, after_profile_o);
        chk("done early", 0, motion_complete_o);
        wait_mc();
        rchk("step", 3, 10);
        chk("driver pos", 10, mpos);
        rchk("target", 4, 10);
        rchk("status", 5, 7);
    endtask : t_move

    task automatic t_define;
        wr(0, 2);
        act_lo <= 1'b0;
        model_clear();
        wr(2, 100);
        rchk("ref def", 2, 100);
        rchk("step def", 3, 100);
        wr(3, 55);
        rchk("step ro", 3, 100);
        wr(4, 95);
        prof(5, 1'b0);
        prof_done_i <= 1'b1;
        wait_mc();
        rchk("step down", 3, 95);
        chk("dir_o", 0, dir_o);
        chk("driver pos", -5, mpos);
    endtask : t_define

    // Encoder on the main input only; aux pins wiggle but stay ignored
    task automatic t_enc;
        logic [1:0] seq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
        wr(6, 7);
        rchk("enc def", 6, 7);
        foreach (seq[i]) begin
            @(posedge sys_clk_i);
            {enc_b_i, enc_a_i} <= seq[i];
            {aux_b_i, aux_a_i} <= seq[i];
            clk(4);
        end
        clk(6);
        rchk("enc count", 6, 11);
        rchk("aux count", 7, 0);
    endtask : t_enc

    task automatic lat(input logic [31:0] k, output int n);
        wr(1, k);
        wr(2, 0);
        prof(4, 1'b1);
        n = 0;
        while (step_o !== 1'b1 && n < 20000) begin
            @(posedge sys_clk_i);
            n++;
        end
        clk(700);
        wr(2, 0);
        prof_done_i <= 1'b1;
        clk(300);
    endtask : lat

    task automatic t_lag;
        lat(0, l0);
        lat(5, l5);
        rchk("smooth k", 1, 5);
        chk("k0 delayed", 1, l0 > 0 && l0 < 20000);
        chk("k5 longer", 1, l5 > l0 && l5 < 20000);
    endtask : t_lag

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // Watchdog
    initial begin
        clk(95000);
        err_count++;
        $display("CHECK FAILED watchdog expected done seen hang");
        end_sim();
    end

    // Main sequence
    initial begin
        err_count = 0;
        check_count = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        {addr_i, wdata_i, wr_i, rd_i, prof_step_i, prof_dir_i, prof_done_i} = '0;
        {enc_a_i, enc_b_i, aux_a_i, aux_b_i, act_lo, clr} = '0;
        clk(2);
        rst_i <= 1'b0;
        t_reset();
        t_kinds();
        t_move();
        t_define();
        t_enc();
        t_lag();
        end_sim();
    end
endmodule : stepper_pulse_output_axis_tb
